// file: core/fieldbus_word_pkg.sv
// Constants and types shared by the fieldbus command/condition word logic
package fieldbus_word_pkg;

  // Mode selection encodings
  localparam logic [1:0] OPERATE_STANDARD = 2'h1;
  localparam logic [1:0] OPERATE_BYPASS   = 2'h2;
  localparam logic [1:0] MACHINE_BASIC    = 2'h1;
  localparam logic [1:0] MACHINE_PROFILE  = 2'h2;

  // Command word bit positions, standard combination
  localparam int CMD_ON1         = 0;
  localparam int CMD_ON2         = 1;
  localparam int CMD_ON3         = 2;
  localparam int CMD_RUN         = 3;
  localparam int CMD_START_A     = 4;
  localparam int CMD_START_B     = 5;
  localparam int CMD_START_C     = 6;
  localparam int CMD_FAULT_RESET = 7;
  localparam int CMD_BUS_CTRL    = 10;
  localparam int CMD_DIN_LO      = 11;
  localparam int DIN_COUNT       = 5;

  // Command word bit positions, three-bit scheme
  localparam int TB_FORWARD = 0;
  localparam int TB_REVERSE = 1;
  localparam int TB_RESET   = 2;

  // Condition word bit positions
  localparam int ST_READY1     = 0;
  localparam int ST_READY2     = 1;
  localparam int ST_ENABLE     = 2;
  localparam int ST_FAULT      = 3;
  localparam int ST_NO_COAST   = 4;
  localparam int ST_NO_QUICK   = 5;
  localparam int ST_START_DIS  = 6;
  localparam int ST_WARNING    = 7;
  localparam int ST_REF_EQ_ACT = 8;
  localparam int ST_BUS_CTRL   = 9;
  localparam int ST_RUNNING    = 12;
  localparam int ST_CONV_READY = 13;

  // Values after reset
  localparam logic [15:0] COMMAND_RESET   = 16'h0000;
  localparam logic [15:0] CONDITION_RESET = 16'h0000;

  typedef enum logic [2:0] {
    COMBO_STANDARD      = 3'b000,
    COMBO_BYPASS_PROFILE = 3'b001,
    COMBO_BYPASS_BASIC  = 3'b010,
    COMBO_REFUSED       = 3'b011
  } combo_t;

endpackage : fieldbus_word_pkg

// file: core/drive_flags_if.sv
// Drive and board state flags passed to the condition word builder
`timescale 1ns/1ps
interface drive_flags_if;
  logic        ready1;
  logic        ready2;
  logic        enable;
  logic        no_coast_stop;
  logic        no_quick_stop;
  logic        start_disable;
  logic        bus_control_on;
  logic        fault_active;
  logic        warning;
  logic        ref_equals_actual;
  logic        running;
  logic        converter_ready;
  logic [15:0] standard_word;

  modport builder (
    input  ready1, ready2, enable, no_coast_stop, no_quick_stop, start_disable,
    input  bus_control_on, fault_active, warning, ref_equals_actual, running,
    input  converter_ready,
    output standard_word
  );
  modport owner (
    output ready1, ready2, enable, no_coast_stop, no_quick_stop, start_disable,
    output bus_control_on, fault_active, warning, ref_equals_actual, running,
    output converter_ready,
    input  standard_word
  );
endinterface : drive_flags_if

// file: core/condition_word_builder.sv
// Registered standard-combination condition word from board and drive flags
`timescale 1ns/1ps
module condition_word_builder
  import fieldbus_word_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  drive_flags_if.builder   flags
);

  typedef struct packed {
    logic [15:0] word;
  } build_state_t;

  build_state_t state_ff;
  build_state_t nxt_state;

  always_comb
  begin
    nxt_state = '0;
    // Board state machine bits
    nxt_state.word[ST_READY1]     = flags.ready1;
    nxt_state.word[ST_READY2]     = flags.ready2;
    nxt_state.word[ST_ENABLE]     = flags.enable;
    nxt_state.word[ST_NO_COAST]   = flags.no_coast_stop;
    nxt_state.word[ST_NO_QUICK]   = flags.no_quick_stop;
    nxt_state.word[ST_START_DIS]  = flags.start_disable;
    nxt_state.word[ST_BUS_CTRL]   = flags.bus_control_on;
    // Drive bits; unused positions stay zero
    nxt_state.word[ST_FAULT]      = flags.fault_active;
    nxt_state.word[ST_WARNING]    = flags.warning;
    nxt_state.word[ST_REF_EQ_ACT] = flags.ref_equals_actual;
    nxt_state.word[ST_RUNNING]    = flags.running;
    nxt_state.word[ST_CONV_READY] = flags.converter_ready;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_ff <= '{word: CONDITION_RESET};
    else
      state_ff <= nxt_state;
  end

  assign flags.standard_word = state_ff.word;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  board_bits_a: assert property (
    ##1 (flags.standard_word[ST_BUS_CTRL] == $past(flags.bus_control_on)) &&
        (flags.standard_word[ST_READY1] == $past(flags.ready1)))
    else $error("board state bits not carried into condition word");

  unused_bits_a: assert property (
    flags.standard_word[11:10] == 2'h0 && flags.standard_word[15:14] == 2'h0)
    else $error("unused condition bits not zero");

endmodule : condition_word_builder

// file: core/fieldbus_word_map.sv
// Fieldbus command word decoder and condition word source selection
//
// Function
// - Standard board mode with profile state machine refuses fieldbus operation.
// - Standard board mode with basic state machine uses board-defined word meanings.
// - Bypass mode with profile state machine passes profile command word to application.
// - Bypass mode with basic state machine decodes a three-bit command scheme.
// - In bypass modes a selector picks condition source, profile word by default.
// - Standard mode: command bit 3 true enables running, false stops the drive.
// - Standard mode: rising edge of command bit 7 resets active faults.
// - Condition bits 0,1,2,4,5,6,9 come from the board state machine.
// - Bits 3,7,12,13 from drive; bit 8 reference reached; 10,11,14,15 unused.
`timescale 1ns/1ps
module fieldbus_word_map
  import fieldbus_word_pkg::*;
#(
  parameter int WORD_W = 16
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [WORD_W-1:0] main_command_word,
  input  wire logic              command_write,
  input  wire logic [1:0]        board_operate_mode_select,
  input  wire logic [1:0]        drive_state_machine_select,
  input  wire logic              status_word_source_select,
  input  wire logic [WORD_W-1:0] profile_status_word,
  input  wire logic [WORD_W-1:0] selected_status_word,
  input  wire logic              board_ready1,
  input  wire logic              board_ready2,
  input  wire logic              board_enable,
  input  wire logic              board_no_coast_stop,
  input  wire logic              board_no_quick_stop,
  input  wire logic              board_start_disable,
  input  wire logic              board_bus_control_on,
  input  wire logic              drive_fault_active,
  input  wire logic              drive_warning,
  input  wire logic              drive_ref_equals_actual,
  input  wire logic              frequency_converter_running,
  input  wire logic              frequency_converter_ready,
  output logic [WORD_W-1:0]      main_condition_word,
  output logic                   bus_operation_refused,
  output logic                   board_defined_words,
  output logic [WORD_W-1:0]      profile_command_word,
  output logic                   profile_command_valid,
  output logic                   run_enable,
  output logic                   fault_reset_pulse,
  output logic                   ramp_stop_request,
  output logic                   coast_stop_request,
  output logic                   bus_control_enable,
  output logic                   bus_digital_input_1,
  output logic                   bus_digital_input_2,
  output logic                   bus_digital_input_3,
  output logic                   bus_digital_input_4,
  output logic                   bus_digital_input_5,
  output logic                   forward_start,
  output logic                   reverse_start
);

  if (WORD_W != 16)
  begin : g_width_check
    $error("fieldbus_word_map serves 16-bit words only");
  end

  typedef struct packed {
    logic [15:0]          cmd;
    combo_t               combo;
    logic                 run_enable;
    logic                 fault_reset;
    logic                 ramp_stop;
    logic                 coast_stop;
    logic                 bus_ctrl;
    logic [DIN_COUNT-1:0] din;
    logic                 fwd;
    logic                 rev;
    logic [15:0]          status;
  } map_state_t;

  map_state_t state_ff;
  map_state_t nxt_state;
  combo_t     combo_now;
  logic [15:0] new_cmd;

  drive_flags_if flags ();

  assign flags.ready1            = board_ready1;
  assign flags.ready2            = board_ready2;
  assign flags.enable            = board_enable;
  assign flags.no_coast_stop     = board_no_coast_stop;
  assign flags.no_quick_stop     = board_no_quick_stop;
  assign flags.start_disable     = board_start_disable;
  assign flags.bus_control_on    = board_bus_control_on;
  assign flags.fault_active      = drive_fault_active;
  assign flags.warning           = drive_warning;
  assign flags.ref_equals_actual = drive_ref_equals_actual;
  assign flags.running           = frequency_converter_running;
  assign flags.converter_ready   = frequency_converter_ready;

  condition_word_builder u_builder (
    .clk   (clk),
    .rst   (rst),
    .flags (flags)
  );

  // Selections other than the four documented pairs are refused as well,
  // so a half-configured drive never acts on fieldbus commands.
  always_comb
  begin
    combo_now = COMBO_REFUSED;
    if (board_operate_mode_select == OPERATE_STANDARD &&
        drive_state_machine_select == MACHINE_BASIC)
      combo_now = COMBO_STANDARD;
    else if (board_operate_mode_select == OPERATE_BYPASS &&
             drive_state_machine_select == MACHINE_PROFILE)
      combo_now = COMBO_BYPASS_PROFILE;
    else if (board_operate_mode_select == OPERATE_BYPASS &&
             drive_state_machine_select == MACHINE_BASIC)
      combo_now = COMBO_BYPASS_BASIC;
  end

  always_comb
  begin
    nxt_state             = state_ff;
    nxt_state.combo       = combo_now;
    nxt_state.fault_reset = 1'b0;
    new_cmd               = command_write ? main_command_word : state_ff.cmd;
    nxt_state.cmd         = new_cmd;
    // Decoded outputs default to safe values each cycle; only the active combination decodes them
    nxt_state.run_enable  = 1'b0;
    nxt_state.ramp_stop   = 1'b0;
    nxt_state.coast_stop  = 1'b0;
    nxt_state.bus_ctrl    = 1'b0;
    nxt_state.din         = '0;
    nxt_state.fwd         = 1'b0;
    nxt_state.rev         = 1'b0;
    nxt_state.status      = CONDITION_RESET;
    unique case (combo_now)
      COMBO_STANDARD:
      begin
        nxt_state.run_enable  = new_cmd[CMD_RUN];
        nxt_state.fault_reset = command_write && new_cmd[CMD_FAULT_RESET] &&
                                !state_ff.cmd[CMD_FAULT_RESET];
        nxt_state.ramp_stop   = !new_cmd[CMD_ON1] || !new_cmd[CMD_ON3];
        nxt_state.coast_stop  = !new_cmd[CMD_ON2];
        nxt_state.bus_ctrl    = new_cmd[CMD_BUS_CTRL];
        nxt_state.din         = new_cmd[CMD_DIN_LO +: DIN_COUNT];
        nxt_state.status      = flags.standard_word;
      end
      COMBO_BYPASS_PROFILE, COMBO_BYPASS_BASIC:
      begin
        if (combo_now == COMBO_BYPASS_BASIC)
        begin
          nxt_state.fwd         = new_cmd[TB_FORWARD];
          nxt_state.rev         = new_cmd[TB_REVERSE];
          nxt_state.fault_reset = command_write && new_cmd[TB_RESET] &&
                                  !state_ff.cmd[TB_RESET];
        end
        nxt_state.status = status_word_source_select ? selected_status_word
                                                     : profile_status_word;
      end
      COMBO_REFUSED:
      begin
        nxt_state.status = CONDITION_RESET;
      end
      default:
      begin
        nxt_state.combo = COMBO_REFUSED;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_ff        <= '0;
      state_ff.cmd    <= COMMAND_RESET;
      state_ff.combo  <= COMBO_REFUSED;
      state_ff.status <= CONDITION_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  assign main_condition_word   = state_ff.status;
  assign bus_operation_refused = state_ff.combo == COMBO_REFUSED;
  assign board_defined_words   = state_ff.combo == COMBO_STANDARD;
  assign profile_command_valid = state_ff.combo == COMBO_BYPASS_PROFILE;
  assign profile_command_word  = profile_command_valid ? state_ff.cmd : '0;
  assign run_enable            = state_ff.run_enable;
  assign fault_reset_pulse     = state_ff.fault_reset;
  assign ramp_stop_request     = state_ff.ramp_stop;
  assign coast_stop_request    = state_ff.coast_stop;
  assign bus_control_enable    = state_ff.bus_ctrl;
  assign bus_digital_input_1   = state_ff.din[0];
  assign bus_digital_input_2   = state_ff.din[1];
  assign bus_digital_input_3   = state_ff.din[2];
  assign bus_digital_input_4   = state_ff.din[3];
  assign bus_digital_input_5   = state_ff.din[4];
  assign forward_start         = state_ff.fwd;
  assign reverse_start         = state_ff.rev;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence std_write_s;
    command_write && combo_now == COMBO_STANDARD;
  endsequence

  sequence fault_edge_s;
    std_write_s ##0 main_command_word[CMD_FAULT_RESET] &&
                    !state_ff.cmd[CMD_FAULT_RESET];
  endsequence

  refused_no_run_a: assert property (
    bus_operation_refused |-> !run_enable && !fault_reset_pulse &&
                              main_condition_word == 16'h0000)
    else $error("refused combination still operates the drive");

  profile_pass_a: assert property (
    command_write && combo_now == COMBO_BYPASS_PROFILE
      |=> profile_command_word == $past(main_command_word))
    else $error("profile command word not passed through");

  three_bit_a: assert property (
    command_write && combo_now == COMBO_BYPASS_BASIC
      |=> forward_start == $past(main_command_word[TB_FORWARD]) &&
          reverse_start == $past(main_command_word[TB_REVERSE]) && !run_enable)
    else $error("three-bit scheme misdecoded");

  source_default_a: assert property (
    combo_now != COMBO_STANDARD && combo_now != COMBO_REFUSED &&
    !status_word_source_select |=> main_condition_word == $past(profile_status_word))
    else $error("default condition source is not the profile word");

  run_follows_a: assert property (
    std_write_s |=> run_enable == $past(main_command_word[CMD_RUN]))
    else $error("run enable does not follow command bit 3");

  fault_reset_edge_a: assert property (
    fault_edge_s |=> fault_reset_pulse ##1 !fault_reset_pulse)
    else $error("fault reset edge not turned into one pulse");

  fault_reset_cause_a: assert property (
    fault_reset_pulse && board_defined_words |-> $past(command_write) &&
      $past(main_command_word[CMD_FAULT_RESET]) && !$past(state_ff.cmd[CMD_FAULT_RESET]))
    else $error("fault reset pulse without a rising bit 7");

  std_status_a: assert property (
    combo_now == COMBO_STANDARD |=> main_condition_word == $past(flags.standard_word))
    else $error("standard condition word not from builder");

  stop_request_a: assert property (
    std_write_s |=> coast_stop_request == !$past(main_command_word[CMD_ON2]) &&
      ramp_stop_request == (!$past(main_command_word[CMD_ON1]) ||
                            !$past(main_command_word[CMD_ON3])))
    else $error("stop requests misdecoded");

  bus_inputs_a: assert property (
    std_write_s |=> bus_control_enable == $past(main_command_word[CMD_BUS_CTRL]) &&
      bus_digital_input_5 == $past(main_command_word[15]) &&
      bus_digital_input_1 == $past(main_command_word[11]))
    else $error("bus control or bus inputs misdecoded");

endmodule : fieldbus_word_map

// file: verification/fieldbus_master_model.sv
// Behavioural fieldbus master that writes command words into the drive
`timescale 1ns/1ps
module fieldbus_master_model
(
  input  wire logic   clk,
  input  wire logic   rst,
  output logic [15:0] main_command_word,
  output logic        command_write
);
  initial
  begin
    main_command_word = 16'h0000;
    command_write     = 1'b0;
  end

  // One write cycle; the idle word is inverted so a stray sample shows up
  task automatic send_word(input logic [15:0] w);
    @(posedge clk);
    while (rst)
    begin
      @(posedge clk);
    end
    main_command_word <= w;
    command_write     <= 1'b1;
    @(posedge clk);
    main_command_word <= ~w;
    command_write     <= 1'b0;
  endtask : send_word
endmodule : fieldbus_master_model

// file: verification/fieldbus_word_map_test.sv
// Self-checking bench for the fieldbus command and condition word map
`timescale 1ns/1ps
module fieldbus_word_map_test;
  import fieldbus_word_pkg::*;

  typedef struct packed {
    logic [1:0]  mode;
    logic [1:0]  machine;
    logic        sel;
    logic [11:0] flags;
    logic [15:0] word;
    logic [13:0] exp_out;
    logic [15:0] exp_cond;
  } row_t;

  logic        clk;
  logic        rst;
  logic [15:0] cmd_word;
  logic        cmd_wr;
  logic [1:0]  mode;
  logic [1:0]  machine;
  logic        sel;
  logic [11:0] flags;
  logic [15:0] prof_word;
  logic [15:0] alt_word;
  wire  [15:0] cond;
  wire  [15:0] pcw;
  wire  [13:0] o;
  wire         pulse;
  row_t        rows [0:9];
  int          err_total;
  int          n_tests;
  int          cycles;

  fieldbus_master_model u_fieldbus_master_model (
    .clk (clk), .rst (rst), .main_command_word (cmd_word), .command_write (cmd_wr)
  );

  fieldbus_word_map u_fieldbus_word_map (
    .clk (clk), .rst (rst), .main_command_word (cmd_word), .command_write (cmd_wr),
    .board_operate_mode_select (mode), .drive_state_machine_select (machine),
    .status_word_source_select (sel), .profile_status_word (prof_word),
    .selected_status_word (alt_word), .board_ready1 (flags[11]),
    .board_ready2 (flags[10]), .board_enable (flags[9]),
    .board_no_coast_stop (flags[8]), .board_no_quick_stop (flags[7]),
    .board_start_disable (flags[6]), .board_bus_control_on (flags[5]),
    .drive_fault_active (flags[4]), .drive_warning (flags[3]),
    .drive_ref_equals_actual (flags[2]), .frequency_converter_running (flags[1]),
    .frequency_converter_ready (flags[0]), .main_condition_word (cond),
    .bus_operation_refused (o[13]), .board_defined_words (o[12]),
    .profile_command_word (pcw), .profile_command_valid (o[11]), .run_enable (o[10]),
    .fault_reset_pulse (pulse), .ramp_stop_request (o[9]), .coast_stop_request (o[8]),
    .bus_control_enable (o[7]), .bus_digital_input_1 (o[6]), .bus_digital_input_2 (o[5]),
    .bus_digital_input_3 (o[4]), .bus_digital_input_4 (o[3]), .bus_digital_input_5 (o[2]),
    .forward_start (o[1]), .reverse_start (o[0])
  );

  task automatic complete_run();
    if (err_total == 0 && n_tests > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      err_total++;
      complete_run();
    end
  end

  initial
  begin
    rst = 1'b1;
    mode = 2'h0;
    machine = 2'h0;
    sel = 1'b0;
    flags = 12'h000;
    prof_word = 16'hA5C3;
    alt_word = 16'h3C5A;
    err_total = 0;
    n_tests = 0;
    cycles = 0;
    rows = '{
      '{OPERATE_STANDARD, MACHINE_BASIC,   1'b0, 12'hFFF, 16'hFC7F, 14'h14FC, 16'h33FF},
      '{OPERATE_STANDARD, MACHINE_BASIC,   1'b0, 12'h012, 16'h0002, 14'h1200, 16'h1008},
      '{OPERATE_STANDARD, MACHINE_BASIC,   1'b0, 12'h889, 16'h0005, 14'h1100, 16'h20A1},
      '{OPERATE_STANDARD, MACHINE_BASIC,   1'b0, 12'h664, 16'h2807, 14'h1050, 16'h0346},
      '{OPERATE_STANDARD, MACHINE_PROFILE, 1'b0, 12'hFFF, 16'hFC7F, 14'h2000, 16'h0000},
      '{OPERATE_BYPASS,   MACHINE_PROFILE, 1'b0, 12'hFFF, 16'h047F, 14'h0800, 16'hA5C3},
      '{OPERATE_BYPASS,   MACHINE_BASIC,   1'b1, 12'hFFF, 16'h0003, 14'h0003, 16'h3C5A},
      '{OPERATE_BYPASS,   MACHINE_BASIC,   1'b0, 12'hFFF, 16'h0001, 14'h0002, 16'hA5C3},
      '{2'h0,             MACHINE_BASIC,   1'b0, 12'hFFF, 16'hFC7F, 14'h2000, 16'h0000},
      '{2'h3,             2'h3,            1'b0, 12'hFFF, 16'hFC7F, 14'h2000, 16'h0000}
    };
    settle(4);
    check("reset outputs", 16'h2000, {2'h0, o});
    check("reset condition", 16'h0000, cond);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      mode    <= rows[i].mode;
      machine <= rows[i].machine;
      sel     <= rows[i].sel;
      flags   <= rows[i].flags;
      u_fieldbus_master_model.send_word(rows[i].word);
      settle(3);
      check("decoded outputs", {2'h0, rows[i].exp_out}, {2'h0, o});
      check("condition word", rows[i].exp_cond, cond);
      check("profile word", rows[i].exp_out[11] ? rows[i].word : 16'h0000, pcw);
    end
    // Fault reset acts on the rising edge only, held high gives no second pulse
    @(posedge clk);
    mode    <= OPERATE_STANDARD;
    machine <= MACHINE_BASIC;
    flags   <= 12'h000;
    u_fieldbus_master_model.send_word(16'h0408);
    u_fieldbus_master_model.send_word(16'h0488);
    #1;
    check("fault pulse", 16'h0001, {15'h0, pulse});
    settle(1);
    check("fault pulse end", 16'h0000, {15'h0, pulse});
    u_fieldbus_master_model.send_word(16'h0488);
    #1;
    check("fault held", 16'h0000, {15'h0, pulse});
    check("run after hold", 16'h0001, {15'h0, o[10]});
    u_fieldbus_master_model.send_word(16'h0480);
    settle(1);
    check("run cleared", 16'h0000, {15'h0, o[10]});
    // Either ramp-stop bit alone asks for a ramp stop and never a coast stop
    u_fieldbus_master_model.send_word(16'h0006);
    #1;
    check("ramp on bit 0", 16'h0002, {14'h0, o[9:8]});
    u_fieldbus_master_model.send_word(16'h0003);
    #1;
    check("ramp on bit 2", 16'h0002, {14'h0, o[9:8]});
    // Standard condition word lags its flag by two edges
    @(posedge clk);
    flags <= 12'h010;
    settle(1);
    check("fault flag early", 16'h0000, cond);
    settle(1);
    check("fault flag", 16'h0008, cond);
    // Three-bit scheme: bit 2 rising requests the fault reset
    @(posedge clk);
    mode <= OPERATE_BYPASS;
    u_fieldbus_master_model.send_word(16'h0000);
    u_fieldbus_master_model.send_word(16'h0004);
    #1;
    check("three bit reset", 16'h0001, {15'h0, pulse});
    // Condition source follows the selected word one edge later
    @(posedge clk);
    prof_word <= 16'h5AA5;
    settle(1);
    check("profile source", 16'h5AA5, cond);
    @(posedge clk);
    sel      <= 1'b1;
    alt_word <= 16'h0FF0;
    settle(1);
    check("selected source", 16'h0FF0, cond);
    // Reset in mid-run clears the decoded outputs and condition word at once and sets refused
    @(posedge clk);
    rst <= 1'b1;
    #1;
    check("mid reset outputs", 16'h2000, {2'h0, o});
    check("mid reset condition", 16'h0000, cond);
    // Stored word is cleared, so nothing is decoded after the release
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(2);
    check("release outputs", 16'h0000, {2'h0, o});
    check("release condition", 16'h0FF0, cond);
    complete_run();
  end
endmodule : fieldbus_word_map_test
